/* File: ref_fault_override_irq_clear.sv */
// Reference fault override, monitor bypass and interrupt clear logic
//
// Summary of operation
// - Four force-fault bits, D high, reset zero
// - Forced-fault reference always reported faulted
// - Four monitor-bypass bits, reset zero, monitor active
// - Bypass reports unfaulted; force-fault has priority
// - Writing one clears monitor bit; zero ignored
// - Clear bits self-clear after one cycle
// - Clear bit n targets monitor bit n
// - Group bits 5..2 clear loops 3..0
// - Group bit1 common, bit0 all, bit7 watchdog
// - System clock bit7 clears unlock event
// - Bit6 clears stable, bit5 clears lock
// - Bit4 clears cal ended, bit3 cal started
// - Bit2 clears watchdog; bits 1:0 reserved
// - Timeout bit zeroes timer of unfaulted reference
`timescale 1ns/100ps

module ref_fault_override_irq_clear (
	input  wire logic        I_CLK,
	input  wire logic        I_ARST_N,
	input  wire logic [11:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [7:0]  O_RDATA,
	input  wire logic [3:0]  I_REF_MON_FAULT,
	input  wire logic [7:0]  I_SYSTEM_CLOCK_SYNTH_EVENT,
	output logic      [3:0]  O_REF_FAULT,
	output logic      [3:0]  O_REF_FORCE,
	output logic      [3:0]  O_REF_BYPASS,
	output logic      [3:0]  O_REF_TIMER_ZERO,
	output logic      [3:0]  O_LOOP_IRQ_CLR,
	output logic             O_COMMON_IRQ_CLR,
	output logic             O_ALL_IRQ_CLR,
	output logic             O_WDOG_ALERT_CLR,
	output logic      [7:0]  O_SYSTEM_CLOCK_SYNTH_IRQ_CLR,
	output logic             O_IRQ
);

	// Address decode, one select per register
	logic       wr_timeout;
	logic       wr_force;
	logic       wr_bypass;
	logic       wr_group;
	logic       wr_system_clock_synth;
	logic       wr_status;
	logic       wr_mask;

	// Control and state registers
	logic [3:0] force_q;
	logic [3:0] bypass_q;
	logic [3:0] fault_d;
	logic [3:0] fault_q;
	logic [3:0] timer_zero_q;
	logic [7:0] status_d;
	logic [7:0] status_q;
	logic [7:0] status_clr;
	logic [7:0] mask_q;
	logic       irq_q;
	logic [7:0] rdata_q;

	// Clear strobes, each held for exactly one cycle
	logic [3:0] loop_clr_q;
	logic       common_clr_q;
	logic       all_clr_q;
	logic       wdog_clr_q;
	logic [7:0] system_clock_synth_clr_q;

	// Write selects; the bus never stalls so decode is pure logic
	assign wr_timeout = I_WR && (I_ADDR == refctl_pkg::OFS_REF_TIMEOUT);
	assign wr_force = I_WR && (I_ADDR == refctl_pkg::OFS_FORCE_FAULT);
	assign wr_bypass = I_WR && (I_ADDR == refctl_pkg::OFS_MON_BYPASS);
	assign wr_group = I_WR && (I_ADDR == refctl_pkg::OFS_GROUP_CLR);
	assign wr_system_clock_synth = I_WR && (I_ADDR == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR);
	assign wr_status = I_WR && (I_ADDR == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS);
	assign wr_mask = I_WR && (I_ADDR == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK);

	// Force-fault bits; only the low nibble is stored
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			force_q <= refctl_pkg::FORCE_FAULT_RST;
		end else if (wr_force) begin
			force_q <= I_WDATA[3:0];
		end
	end

	// Monitor-bypass bits
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bypass_q <= refctl_pkg::MON_BYPASS_RST;
		end else if (wr_bypass) begin
			bypass_q <= I_WDATA[3:0];
		end
	end

	// Fault verdict per reference; force wins over bypass
	always_comb begin
		fault_d = force_q | (I_REF_MON_FAULT & ~bypass_q);
	end

	// Registered fault view so the outputs come from flops
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			fault_q <= 4'h0;
		end else begin
			fault_q <= fault_d;
		end
	end

	// Timeout pulse; ignored for a reference that is faulted now
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			timer_zero_q <= 4'h0;
		end else if (wr_timeout) begin
			timer_zero_q <= I_WDATA[3:0] & ~fault_q;
		end else begin
			timer_zero_q <= 4'h0;
		end
	end

	// Group clear strobes, one cycle after the write
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			loop_clr_q <= 4'h0;
			common_clr_q <= 1'b0;
			all_clr_q <= 1'b0;
			wdog_clr_q <= 1'b0;
		end else if (wr_group) begin
			// Bit 6 is reserved and has no strobe
			loop_clr_q <= I_WDATA[5:2];
			common_clr_q <= I_WDATA[refctl_pkg::GRP_COMMON_BIT];
			all_clr_q <= I_WDATA[refctl_pkg::GRP_ALL_BIT];
			wdog_clr_q <= I_WDATA[refctl_pkg::GRP_WDOG_BIT];
		end else begin
			// Self-clearing: software never writes a zero
			loop_clr_q <= 4'h0;
			common_clr_q <= 1'b0;
			all_clr_q <= 1'b0;
			wdog_clr_q <= 1'b0;
		end
	end

	// System clock clear strobes keep the monitor layout bit for bit
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			system_clock_synth_clr_q <= 8'h00;
		end else if (wr_system_clock_synth) begin
			// Bits 7..2 map to events; 1:0 stay zero
			system_clock_synth_clr_q <= I_WDATA & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID;
		end else begin
			system_clock_synth_clr_q <= 8'h00;
		end
	end

	// Sources that clear the local system clock monitor bits
	always_comb begin
		status_clr = 8'h00;
		if (wr_system_clock_synth) begin
			status_clr = I_WDATA & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID;
		end
		if (wr_status) begin
			status_clr = status_clr | I_WDATA;
		end
		if (wr_group && (I_WDATA[refctl_pkg::GRP_ALL_BIT] ||
			I_WDATA[refctl_pkg::GRP_COMMON_BIT])) begin
			status_clr = 8'hff;
		end
		if (wr_group && I_WDATA[refctl_pkg::GRP_WDOG_BIT]) begin
			status_clr[refctl_pkg::SC_WDOG_BIT] = 1'b1;
		end
	end

	// A new event in the clear cycle survives the clear
	always_comb begin
		status_d = (status_q & ~status_clr) |
			(I_SYSTEM_CLOCK_SYNTH_EVENT & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID);
	end

	// Sticky system clock monitor bits
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			status_q <= refctl_pkg::STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	// Interrupt mask, same layout as the monitor bits
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			mask_q <= refctl_pkg::MASK_RST;
		end else if (wr_mask) begin
			mask_q <= I_WDATA & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID;
		end
	end

	// Level interrupt, computed from next values to avoid a lag
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			irq_q <= 1'b0;
		end else if (wr_mask) begin
			irq_q <= |(status_d & I_WDATA & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID);
		end else begin
			irq_q <= |(status_d & mask_q);
		end
	end

	// Read port; data stand only in the cycle after the strobe
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_q <= refctl_pkg::RDATA_RST;
		end else if (I_RD) begin
			case (I_ADDR)
				refctl_pkg::OFS_FORCE_FAULT: begin
					rdata_q <= {4'h0, force_q};
				end
				refctl_pkg::OFS_MON_BYPASS: begin
					rdata_q <= {4'h0, bypass_q};
				end
				refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS: begin
					rdata_q <= status_q;
				end
				refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK: begin
					rdata_q <= mask_q;
				end
				// Timeout and clear registers self-clear
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Outputs straight from flops
	assign O_RDATA = rdata_q;
	assign O_REF_FAULT = fault_q;
	assign O_REF_FORCE = force_q;
	assign O_REF_BYPASS = bypass_q;
	assign O_REF_TIMER_ZERO = timer_zero_q;
	assign O_LOOP_IRQ_CLR = loop_clr_q;
	assign O_COMMON_IRQ_CLR = common_clr_q;
	assign O_ALL_IRQ_CLR = all_clr_q;
	assign O_WDOG_ALERT_CLR = wdog_clr_q;
	assign O_SYSTEM_CLOCK_SYNTH_IRQ_CLR = system_clock_synth_clr_q;
	assign O_IRQ = irq_q;

	// Checks on the block's own outputs
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	// A forced reference shows faulted one cycle later
	force_wins_a: assert property (
		(($past(force_q) & ~O_REF_FAULT) == 4'h0))
		else $error("forced reference not reported faulted");

	// Bypassed and unforced reference reads unfaulted
	bypass_unfault_a: assert property (
		((bypass_q & ~force_q) != 4'h0) ##1
		((bypass_q & ~force_q) == $past(bypass_q & ~force_q))
		|-> ((O_REF_FAULT & $past(bypass_q & ~force_q)) == 4'h0))
		else $error("bypassed reference reported faulted");

	// Force-fault write lands two cycles later on the fault view
	force_write_a: assert property (
		wr_force ##1 !wr_force
		|=> (O_REF_FAULT & $past(I_WDATA[3:0], 2)) ==
			$past(I_WDATA[3:0], 2))
		else $error("force write did not fault reference");

	// Loop clear strobes follow group bits 5..2
	loop_clear_a: assert property (
		wr_group |=> O_LOOP_IRQ_CLR == $past(I_WDATA[5:2]))
		else $error("loop clear mapping wrong");

	// Strobes vanish when no clear write is made
	self_clear_a: assert property (
		!wr_group && !wr_system_clock_synth |=>
		(O_LOOP_IRQ_CLR == 4'h0) && !O_ALL_IRQ_CLR &&
		!O_COMMON_IRQ_CLR && !O_WDOG_ALERT_CLR &&
		(O_SYSTEM_CLOCK_SYNTH_IRQ_CLR == 8'h00))
		else $error("clear strobe did not self-clear");

	// Writing zero gives no strobe; reserved bits never strobe
	zero_write_a: assert property (
		wr_system_clock_synth |=> (O_SYSTEM_CLOCK_SYNTH_IRQ_CLR[1:0] == 2'b00) &&
		(O_SYSTEM_CLOCK_SYNTH_IRQ_CLR[7:2] == $past(I_WDATA[7:2])))
		else $error("system clock clear layout wrong");

	// Clearing the unlock bit drops it unless a new event came
	unlock_clear_a: assert property (
		wr_system_clock_synth && I_WDATA[refctl_pkg::SC_UNLOCK_BIT] &&
		!I_SYSTEM_CLOCK_SYNTH_EVENT[refctl_pkg::SC_UNLOCK_BIT]
		|=> !status_q[refctl_pkg::SC_UNLOCK_BIT])
		else $error("unlock monitor bit not cleared");

	// An event in the clear cycle is kept
	set_wins_a: assert property (
		(I_SYSTEM_CLOCK_SYNTH_EVENT & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID) != 8'h00
		|=> (status_q & $past(I_SYSTEM_CLOCK_SYNTH_EVENT &
			refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID)) ==
			$past(I_SYSTEM_CLOCK_SYNTH_EVENT & refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID))
		else $error("event lost against clear");

	// Clear registers read zero
	clear_read_a: assert property (
		I_RD && ((I_ADDR == refctl_pkg::OFS_GROUP_CLR) ||
		(I_ADDR == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR)) |=> O_RDATA == 8'h00)
		else $error("clear register read not zero");

	// Timer-zero pulse only for an unfaulted reference
	timeout_gate_a: assert property (
		wr_timeout |=> (O_REF_TIMER_ZERO & $past(fault_q)) == 4'h0)
		else $error("timeout pulse for faulted reference");

	// Interrupt level tracks masked status
	irq_level_a: assert property (
		O_IRQ == |(status_q & mask_q))
		else $error("interrupt level mismatch");

	// Force and bypass registers take the written low nibble
	force_reg_a: assert property (
		wr_force |=> O_REF_FORCE == $past(I_WDATA[3:0]))
		else $error("force register not written");

	bypass_write_a: assert property (
		wr_bypass |=> O_REF_BYPASS == $past(I_WDATA[3:0]))
		else $error("bypass register not written");

	// Watchdog, common and all strobes follow group bits 7, 1 and 0
	group_strobe_a: assert property (
		wr_group |=> {O_WDOG_ALERT_CLR, O_COMMON_IRQ_CLR,
			O_ALL_IRQ_CLR} == $past({I_WDATA[7], I_WDATA[1],
			I_WDATA[0]}))
		else $error("group clear strobe mapping wrong");

	// Each cleared monitor bit drops unless its event came again
	clear_drop_a: assert property (
		wr_system_clock_synth |=> (status_q & $past(I_WDATA & ~I_SYSTEM_CLOCK_SYNTH_EVENT &
			refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID)) == 8'h00)
		else $error("system clock monitor bit not cleared");

	// A clear write of zero leaves every monitor bit alone
	zero_keep_a: assert property (
		wr_system_clock_synth && (I_WDATA == 8'h00) |=> status_q ==
			($past(status_q) | $past(I_SYSTEM_CLOCK_SYNTH_EVENT &
			refctl_pkg::SYSTEM_CLOCK_SYNTH_VALID)))
		else $error("zero clear changed a monitor bit");

	// Timer-zero pulse lasts one cycle only
	timer_pulse_a: assert property (
		!wr_timeout |=> O_REF_TIMER_ZERO == 4'h0)
		else $error("timer zero pulse did not end");

	// Read data fall back to zero outside a read
	rdata_idle_a: assert property (
		!I_RD |=> O_RDATA == 8'h00)
		else $error("read data stood too long");

	// Main scenarios
	all_clear_c: cover property (wr_group && I_WDATA[0] ##1 O_ALL_IRQ_CLR);
	collide_c: cover property (wr_system_clock_synth && (I_WDATA &
		I_SYSTEM_CLOCK_SYNTH_EVENT) != 8'h00);
	force_bypass_c: cover property ((force_q & bypass_q) != 4'h0);
	irq_rise_c: cover property (!O_IRQ ##1 O_IRQ);
	timer_zero_c: cover property (O_REF_TIMER_ZERO != 4'h0);

endmodule // ref_fault_override_irq_clear

/* File: refctl_pkg.sv */
// Constants shared by the reference fault and interrupt clear block
package refctl_pkg;

	// Bus and field widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int NUM_REF = 4;
	localparam int NUM_LOOP = 4;

	// Register offsets
	localparam logic [11:0] OFS_REF_TIMEOUT = 12'ha02;
	localparam logic [11:0] OFS_FORCE_FAULT = 12'ha03;
	localparam logic [11:0] OFS_MON_BYPASS = 12'ha04;
	localparam logic [11:0] OFS_GROUP_CLR = 12'ha05;
	localparam logic [11:0] OFS_SYSTEM_CLOCK_SYNTH_CLR = 12'ha06;
	localparam logic [11:0] OFS_SYSTEM_CLOCK_SYNTH_STATUS = 12'hd30;
	localparam logic [11:0] OFS_SYSTEM_CLOCK_SYNTH_MASK = 12'hd31;

	// Group clear bit positions
	localparam int GRP_ALL_BIT = 0;
	localparam int GRP_COMMON_BIT = 1;
	localparam int GRP_LOOP_LSB = 2;
	localparam int GRP_WDOG_BIT = 7;

	// System clock event bit positions
	localparam int SC_UNLOCK_BIT = 7;
	localparam int SC_STABLE_BIT = 6;
	localparam int SC_LOCK_BIT = 5;
	localparam int SC_CAL_END_BIT = 4;
	localparam int SC_CAL_START_BIT = 3;
	localparam int SC_WDOG_BIT = 2;

	// Implemented bits; the rest are reserved and read zero
	localparam logic [7:0] SYSTEM_CLOCK_SYNTH_VALID = 8'hfc;
	localparam logic [7:0] GROUP_VALID = 8'hbf;

	// Values after reset
	localparam logic [3:0] FORCE_FAULT_RST = 4'h0;
	localparam logic [3:0] MON_BYPASS_RST = 4'h0;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

/* File: testbench.sv */
// Self-checking bench for the reference fault and interrupt clear block
`timescale 1ns/100ps

module testbench;
	logic        I_CLK = 1'b0;
	logic        I_ARST_N = 1'b0;
	logic [11:0] I_ADDR = 12'h000;
	logic [7:0]  I_WDATA = 8'h00;
	logic        I_WR = 1'b0;
	logic        I_RD = 1'b0;
	logic [3:0]  I_REF_MON_FAULT = 4'h0;
	logic [7:0]  I_SYSTEM_CLOCK_SYNTH_EVENT = 8'h00;
	logic [7:0]  O_RDATA;
	logic [7:0]  O_SYSTEM_CLOCK_SYNTH_IRQ_CLR;
	logic [3:0]  O_REF_FAULT;
	logic [3:0]  O_REF_FORCE;
	logic [3:0]  O_REF_BYPASS;
	logic [3:0]  O_REF_TIMER_ZERO;
	logic [3:0]  O_LOOP_IRQ_CLR;
	logic        O_COMMON_IRQ_CLR;
	logic        O_ALL_IRQ_CLR;
	logic        O_WDOG_ALERT_CLR;
	logic        O_IRQ;
	logic [7:0]  grp;
	logic [7:0]  st;
	logic [7:0]  ev;
	logic [3:0]  ff;
	logic [3:0]  bp;
	logic [3:0]  mon;
	int          mismatches = 0;
	int          n_compared = 0;
	int          m_status = 0;
	int          m_mask = 0;
	int          clr_q[$];

	// 250 MHz clock
	always #2 I_CLK = ~I_CLK;

	// Group strobes gathered in the clear register layout
	assign grp = {O_WDOG_ALERT_CLR, 1'b0, O_LOOP_IRQ_CLR,
		O_COMMON_IRQ_CLR, O_ALL_IRQ_CLR};

	ref_fault_override_irq_clear uut (
		.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
		.I_REF_MON_FAULT(I_REF_MON_FAULT), .I_SYSTEM_CLOCK_SYNTH_EVENT(I_SYSTEM_CLOCK_SYNTH_EVENT),
		.O_REF_FAULT(O_REF_FAULT), .O_REF_FORCE(O_REF_FORCE),
		.O_REF_BYPASS(O_REF_BYPASS), .O_REF_TIMER_ZERO(O_REF_TIMER_ZERO),
		.O_LOOP_IRQ_CLR(O_LOOP_IRQ_CLR), .O_COMMON_IRQ_CLR(O_COMMON_IRQ_CLR),
		.O_ALL_IRQ_CLR(O_ALL_IRQ_CLR), .O_WDOG_ALERT_CLR(O_WDOG_ALERT_CLR),
		.O_SYSTEM_CLOCK_SYNTH_IRQ_CLR(O_SYSTEM_CLOCK_SYNTH_IRQ_CLR), .O_IRQ(O_IRQ)
	);

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Model of the monitor and mask bits, written from the rules
	function automatic void mdl(input logic [11:0] a, input int d,
		input int e);
		if ((a == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR) ||
			(a == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS))
			m_status = m_status & ~d;
		if ((a == refctl_pkg::OFS_GROUP_CLR) && ((d & 'h03) != 0))
			m_status = 0;
		if ((a == refctl_pkg::OFS_GROUP_CLR) && ((d & 'h80) != 0))
			m_status = m_status & ~'h04;
		if (a == refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK)
			m_mask = d & 'hfc;
		// Event in the clear cycle wins; bits 1:0 never latch
		m_status = (m_status | e) & 'hfc;
	endfunction

	// Interrupt level the model expects
	function automatic logic [7:0] irq_exp();
		return {7'h00, (m_status & m_mask) != 0};
	endfunction

	// One write cycle; an event pattern may ride along in the same cycle
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] e);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		I_SYSTEM_CLOCK_SYNTH_EVENT <= e;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		I_SYSTEM_CLOCK_SYNTH_EVENT <= 8'h00;
		mdl(a, int'(d), int'(e));
		#1;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		chk($sformatf("read %h", a), e, O_RDATA);
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard, well above the length of the run
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end

	initial begin
		void'($urandom(4527));
		st = 8'h00;
		repeat (16) @(posedge I_CLK);
		I_ARST_N <= 1'b1;
		for (int i = 2; i < 7; i++) begin
			rdc(12'ha00 + 12'(i), 8'h00);
		end
		chk("fault", 8'h00, {4'h0, O_REF_FAULT});
		$display("test reset done");

		// Random force, bypass and monitor mixes; upper nibble reserved
		for (int i = 0; i < 16; i++) begin
			ff = 4'($urandom);
			bp = 4'($urandom);
			mon = 4'($urandom);
			wr(refctl_pkg::OFS_FORCE_FAULT, {4'hf, ff}, 8'h00);
			wr(refctl_pkg::OFS_MON_BYPASS, {4'hf, bp}, 8'h00);
			@(posedge I_CLK);
			I_REF_MON_FAULT <= mon;
			repeat (2) @(posedge I_CLK);
			#1;
			chk("fault", {4'h0, ff | (mon & ~bp)}, {4'h0, O_REF_FAULT});
			chk("force", {4'h0, ff}, {4'h0, O_REF_FORCE});
			chk("bypass", {4'h0, bp}, {4'h0, O_REF_BYPASS});
			rdc(refctl_pkg::OFS_FORCE_FAULT, {4'h0, ff});
			rdc(refctl_pkg::OFS_MON_BYPASS, {4'h0, bp});
		end
		$display("test fault override done");

		// Timeout pulse only for references seen unfaulted
		wr(refctl_pkg::OFS_MON_BYPASS, 8'h00, 8'h00);
		@(posedge I_CLK);
		I_REF_MON_FAULT <= 4'h4;
		wr(refctl_pkg::OFS_FORCE_FAULT, 8'h01, 8'h00);
		repeat (2) @(posedge I_CLK);
		wr(12'ha02, 8'h0f, 8'h00);
		chk("timer zero", 8'h0a, {4'h0, O_REF_TIMER_ZERO});
		@(posedge I_CLK);
		#1;
		chk("timer zero end", 8'h00, {4'h0, O_REF_TIMER_ZERO});
		$display("test timeout done");

		// Every single bit of both clear registers, then self-clear
		for (int i = 0; i < 8; i++) begin
			wr(refctl_pkg::OFS_GROUP_CLR, 8'(1 << i), 8'h00);
			chk("group clr", 8'(1 << i) & 8'hbf, grp);
			@(posedge I_CLK);
			#1;
			chk("group end", 8'h00, grp);
			wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR, 8'(1 << i), 8'h00);
			chk("sys clr", 8'(1 << i) & 8'hfc, O_SYSTEM_CLOCK_SYNTH_IRQ_CLR);
			@(posedge I_CLK);
			#1;
			chk("sys end", 8'h00, O_SYSTEM_CLOCK_SYNTH_IRQ_CLR);
		end
		rdc(refctl_pkg::OFS_GROUP_CLR, 8'h00);
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR, 8'h00);
		$display("test clear strobes done");

		// Raise each event, try zero clear, clash clear, real clear
		wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'hff, 8'h00);
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'hfc);
		for (int k = 2; k < 8; k++) begin
			ev = 8'(1 << k);
			wr(12'h0ff, 8'h5a, ev);
			chk("irq set", 8'h01, {7'h00, O_IRQ});
			rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, 8'(m_status));
			wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR, 8'h00, 8'h00);
			chk("irq zero clr", 8'h01, {7'h00, O_IRQ});
			wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR, ev, ev);
			chk("irq clash", 8'h01, {7'h00, O_IRQ});
			wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR, ev, 8'h00);
			chk("irq cleared", 8'h00, {7'h00, O_IRQ});
			rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, 8'h00);
		end
		rdc(12'h0ff, 8'h00);
		$display("test events done");

		// Masked event keeps the line low; group bits clear status
		wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'h00, 8'h00);
		wr(12'h0ff, 8'h00, 8'h84);
		st = 8'h84;
		chk("irq masked", 8'h00, {7'h00, O_IRQ});
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, st);
		wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'h80, 8'h00);
		@(posedge I_CLK);
		#1;
		chk("irq unmasked", 8'h01, {7'h00, O_IRQ});
		wr(refctl_pkg::OFS_GROUP_CLR, 8'h80, 8'h00);
		st = 8'h80;
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, st);
		wr(refctl_pkg::OFS_GROUP_CLR, 8'h01, 8'h00);
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, 8'h00);
		chk("irq all clr", 8'h00, {7'h00, O_IRQ});
		$display("test mask and group done");

		// Random clears, direct status writes and events against the model
		clr_q.push_back(int'(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_CLR));
		clr_q.push_back(int'(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS));
		clr_q.push_back(int'(refctl_pkg::OFS_GROUP_CLR));
		wr(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'($urandom), 8'h00);
		rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_MASK, 8'(m_mask));
		for (int i = 0; i < 24; i++) begin
			wr(12'(clr_q[i % 3]), 8'($urandom), 8'($urandom));
			chk("irq model", irq_exp(), {7'h00, O_IRQ});
			rdc(refctl_pkg::OFS_SYSTEM_CLOCK_SYNTH_STATUS, 8'(m_status));
		end
		$display("test random model done");
		print_verdict();
	end
endmodule // testbench
